// ---- rtl/csc_pkg.sv ----
package csc_pkg;

  // Widths of the core datapaths
  localparam int CSC_PC_W   = 12;
  localparam int CSC_SP_W   = 8;
  localparam int CSC_DATA_W = 8;
  localparam int CSC_WORD_W = 16;
  localparam int CSC_OP_W   = 4;

  // Stack pointer step per pushed or popped return address
  localparam logic [CSC_SP_W-1:0] CSC_SP_STEP = 8'h02;
  // Program counter step for straight-line flow
  localparam logic [CSC_PC_W-1:0] CSC_PC_STEP = 12'h001;

  // Reset values of held datapath outputs
  localparam logic [CSC_PC_W-1:0]   CSC_PC_RST   = 12'h000;
  localparam logic [CSC_SP_W-1:0]   CSC_SP_RST   = 8'h00;
  localparam logic [CSC_DATA_W-1:0] CSC_DATA_RST = 8'h00;
  localparam logic [CSC_WORD_W-1:0] CSC_WORD_RST = 16'h0000;

  // Operation codes presented by the upstream decoder
  localparam logic [CSC_OP_W-1:0] CSC_OP_NOP     = 4'h0;
  localparam logic [CSC_OP_W-1:0] CSC_OP_CALL    = 4'h1;
  localparam logic [CSC_OP_W-1:0] CSC_OP_GOTO    = 4'h2;
  localparam logic [CSC_OP_W-1:0] CSC_OP_RETIMM  = 4'h3;
  localparam logic [CSC_OP_W-1:0] CSC_OP_RET     = 4'h4;
  localparam logic [CSC_OP_W-1:0] CSC_OP_RETI    = 4'h5;
  localparam logic [CSC_OP_W-1:0] CSC_OP_PCADD   = 4'h6;
  localparam logic [CSC_OP_W-1:0] CSC_OP_INTON   = 4'h7;
  localparam logic [CSC_OP_W-1:0] CSC_OP_INTOFF  = 4'h8;
  localparam logic [CSC_OP_W-1:0] CSC_OP_STOPSYS = 4'h9;
  localparam logic [CSC_OP_W-1:0] CSC_OP_STOPCPU = 4'hA;
  localparam logic [CSC_OP_W-1:0] CSC_OP_SWRST   = 4'hB;
  localparam logic [CSC_OP_W-1:0] CSC_OP_WDCLR   = 4'hC;

  // Program counter source in the final phase
  typedef enum logic [1:0] {CSC_PC_INC, CSC_PC_TGT, CSC_PC_ADD, CSC_PC_POP} csc_pcsel_t;

  // Execution phases
  typedef enum logic [0:0] {CSC_IDLE, CSC_SECOND} csc_state_t;

  // Wrapping stack pointer arithmetic
  function automatic logic [CSC_SP_W-1:0] csc_sp_add(input logic [CSC_SP_W-1:0] sp);
    csc_sp_add = CSC_SP_W'(sp + CSC_SP_STEP);
  endfunction : csc_sp_add

  function automatic logic [CSC_SP_W-1:0] csc_sp_sub(input logic [CSC_SP_W-1:0] sp);
    csc_sp_sub = CSC_SP_W'(sp - CSC_SP_STEP);
  endfunction : csc_sp_sub

  // Operations that take two instruction cycles
  function automatic logic csc_is_long(input logic [CSC_OP_W-1:0] op);
    csc_is_long = (op == CSC_OP_CALL) || (op == CSC_OP_GOTO) || (op == CSC_OP_RETIMM)
               || (op == CSC_OP_RET) || (op == CSC_OP_RETI) || (op == CSC_OP_PCADD);
  endfunction : csc_is_long

endpackage : csc_pkg

// ---- rtl/csc_pc_calc.sv ----
module csc_pc_calc
  import csc_pkg::*;
(
  input  wire logic [CSC_PC_W-1:0]   pcBase,
  input  wire logic [CSC_DATA_W-1:0] accVal,
  input  wire logic [CSC_PC_W-1:0]   target,
  input  wire logic [CSC_WORD_W-1:0] popWord,
  input  wire csc_pcsel_t            pcSel,
  output logic      [CSC_PC_W-1:0]   pcOut,
  output logic      [CSC_PC_W-1:0]   pcInc
);

  // Address of the following instruction
  assign pcInc = CSC_PC_W'(pcBase + CSC_PC_STEP);

  // Next program counter by source
  always_comb
  begin
    unique case (pcSel)
      CSC_PC_INC: pcOut = pcInc;
      CSC_PC_TGT: pcOut = target;
      CSC_PC_ADD: pcOut = CSC_PC_W'(pcBase + {{(CSC_PC_W-CSC_DATA_W){1'b0}}, accVal});
      CSC_PC_POP: pcOut = popWord[CSC_PC_W-1:0];
    endcase
  end

endmodule : csc_pc_calc

// ---- rtl/csc_sysctl_exec.sv ----
// Function
// - Call pushes next address at sp, then loads target while sp grows by two.
// - Jump loads its target; call and jump reach the whole program space.
// - Return-with-value writes the immediate to the accumulator, then returns.
// - Return drops sp by two, then reloads pc from the stack there.
// - Return from interrupt returns and sets the global interrupt enable in the same cycle as the pc reload.
// - Computed jump sets pc to current pc plus unsigned accumulator.
// - Interrupt-enable op sets the global enable.
// - Interrupt-disable op clears the global enable.
// - Full stop halts the system and all clocks including oscillators.
// - CPU stop gates the core clock, oscillators keep running.
// - Software reset resets the whole chip like a hardware reset.
// - Watchdog restart clears the watchdog count.
// - Jumps, calls, returns and computed jump take two cycles, others one.
module csc_sysctl_exec
  import csc_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic                  opValid,
  output logic                       opReady,
  input  wire logic [CSC_OP_W-1:0]   opCode,
  input  wire logic [CSC_DATA_W-1:0] opImm,
  input  wire logic [CSC_PC_W-1:0]   opTarget,
  input  wire logic [CSC_PC_W-1:0]   pcCur,
  input  wire logic [CSC_DATA_W-1:0] accCur,
  input  wire logic [CSC_SP_W-1:0]   spCur,
  input  wire logic [CSC_WORD_W-1:0] memRdata,
  output logic                       opDone,
  output logic                       pcLoad,
  output logic      [CSC_PC_W-1:0]   pcNext,
  output logic                       accWe,
  output logic      [CSC_DATA_W-1:0] accData,
  output logic                       spWe,
  output logic      [CSC_SP_W-1:0]   spNext,
  output logic                       memWe,
  output logic                       memRd,
  output logic      [CSC_SP_W-1:0]   memAddr,
  output logic      [CSC_WORD_W-1:0] memWdata,
  output logic                       flagsWe,
  output logic                       gieSet,
  output logic                       gieClr,
  output logic                       haltSys,
  output logic                       haltCpu,
  output logic                       chipReset,
  output logic                       wdtClear
);

  csc_state_t            state;
  csc_state_t            next_state;
  logic [CSC_OP_W-1:0]   opReg;
  logic [CSC_OP_W-1:0]   next_opReg;
  logic [CSC_PC_W-1:0]   tgtReg;
  logic [CSC_PC_W-1:0]   next_tgtReg;
  logic [CSC_PC_W-1:0]   pcReg;
  logic [CSC_PC_W-1:0]   next_pcReg;
  logic [CSC_DATA_W-1:0] accReg;
  logic [CSC_DATA_W-1:0] next_accReg;
  logic [CSC_SP_W-1:0]   spReg;
  logic [CSC_SP_W-1:0]   next_spReg;
  logic                  next_opDone;
  logic                  next_pcLoad;
  logic [CSC_PC_W-1:0]   next_pcNext;
  logic                  next_accWe;
  logic [CSC_DATA_W-1:0] next_accData;
  logic                  next_spWe;
  logic [CSC_SP_W-1:0]   next_spNext;
  logic                  next_memWe;
  logic                  next_memRd;
  logic [CSC_SP_W-1:0]   next_memAddr;
  logic [CSC_WORD_W-1:0] next_memWdata;
  logic                  next_gieSet;
  logic                  next_gieClr;
  logic                  next_haltSys;
  logic                  next_haltCpu;
  logic                  next_chipReset;
  logic                  next_wdtClear;
  logic                  take;
  csc_pcsel_t            pcSel;
  logic [CSC_PC_W-1:0]   pcFinal;
  logic [CSC_PC_W-1:0]   pcInc;
  logic [CSC_PC_W-1:0]   pcBase;

  // New operations are taken only between operations
  assign opReady = (state == CSC_IDLE);
  assign take    = opValid && opReady;
  // One-cycle ops use the live pc, second phase uses the captured one
  assign pcBase  = (state == CSC_IDLE) ? pcCur : pcReg;

  // Program counter source for the final phase
  always_comb
  begin
    unique case (opReg)
      CSC_OP_CALL, CSC_OP_GOTO:                 pcSel = CSC_PC_TGT;
      CSC_OP_PCADD:                             pcSel = CSC_PC_ADD;
      CSC_OP_RET, CSC_OP_RETIMM, CSC_OP_RETI:   pcSel = CSC_PC_POP;
      default:                                  pcSel = CSC_PC_INC;
    endcase
  end

  csc_pc_calc u_pc_calc (
    .pcBase  (pcBase),
    .accVal  (accReg),
    .target  (tgtReg),
    .popWord (memRdata),
    .pcSel   (pcSel),
    .pcOut   (pcFinal),
    .pcInc   (pcInc)
  );

  // Next-state and output computation
  always_comb
  begin
    next_state     = state;
    next_opReg     = opReg;
    next_tgtReg    = tgtReg;
    next_pcReg     = pcReg;
    next_accReg    = accReg;
    next_spReg     = spReg;
    next_pcNext    = pcNext;
    next_accData   = accData;
    next_spNext    = spNext;
    next_memAddr   = memAddr;
    next_memWdata  = memWdata;
    next_opDone    = 1'b0;
    next_pcLoad    = 1'b0;
    next_accWe     = 1'b0;
    next_spWe      = 1'b0;
    next_memWe     = 1'b0;
    next_memRd     = 1'b0;
    next_gieSet    = 1'b0;
    next_gieClr    = 1'b0;
    next_haltSys   = 1'b0;
    next_haltCpu   = 1'b0;
    next_chipReset = 1'b0;
    next_wdtClear  = 1'b0;
    unique case (state)
      CSC_IDLE:
      begin
        if (take)
        begin
          next_opReg  = opCode;
          next_tgtReg = opTarget;
          next_pcReg  = pcCur;
          next_accReg = accCur;
          next_spReg  = spCur;
          if (csc_is_long(opCode))
          begin
            next_state = CSC_SECOND;
          end
          else
          begin
            next_opDone = 1'b1;
          end
          unique case (opCode)
            CSC_OP_CALL:
            begin
              next_memWe    = 1'b1;
              next_memAddr  = spCur;
              next_memWdata = {{(CSC_WORD_W-CSC_PC_W){1'b0}}, pcInc};
            end
            CSC_OP_RETIMM, CSC_OP_RET, CSC_OP_RETI:
            begin
              next_spWe    = 1'b1;
              next_spNext  = csc_sp_sub(spCur);
              next_memRd   = 1'b1;
              next_memAddr = csc_sp_sub(spCur);
              if (opCode == CSC_OP_RETIMM)
              begin
                next_accWe   = 1'b1;
                next_accData = opImm;
              end
            end
            CSC_OP_NOP, CSC_OP_INTON, CSC_OP_INTOFF, CSC_OP_STOPSYS,
            CSC_OP_STOPCPU, CSC_OP_WDCLR:
            begin
              next_pcLoad    = 1'b1;
              next_pcNext    = pcInc;
              next_gieSet    = (opCode == CSC_OP_INTON);
              next_gieClr    = (opCode == CSC_OP_INTOFF);
              next_haltSys   = (opCode == CSC_OP_STOPSYS);
              next_haltCpu   = (opCode == CSC_OP_STOPCPU);
              next_wdtClear  = (opCode == CSC_OP_WDCLR);
            end
            CSC_OP_GOTO, CSC_OP_PCADD:
            begin
              next_opDone = 1'b0;
            end
            CSC_OP_SWRST:
            begin
              next_chipReset = 1'b1;
            end
            default:
            begin
              next_opDone = 1'b1;
            end
          endcase
        end
      end
      CSC_SECOND:
      begin
        next_state  = CSC_IDLE;
        next_opDone = 1'b1;
        next_pcLoad = 1'b1;
        next_pcNext = pcFinal;
        if (opReg == CSC_OP_CALL)
        begin
          next_spWe   = 1'b1;
          next_spNext = csc_sp_add(spReg);
        end
        next_gieSet = (opReg == CSC_OP_RETI);
      end
    endcase
  end

  // State and output registers
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state     <= CSC_IDLE;
      opReg     <= CSC_OP_NOP;
      tgtReg    <= CSC_PC_RST;
      pcReg     <= CSC_PC_RST;
      accReg    <= CSC_DATA_RST;
      spReg     <= CSC_SP_RST;
      opDone    <= 1'b0;
      pcLoad    <= 1'b0;
      pcNext    <= CSC_PC_RST;
      accWe     <= 1'b0;
      accData   <= CSC_DATA_RST;
      spWe      <= 1'b0;
      spNext    <= CSC_SP_RST;
      memWe     <= 1'b0;
      memRd     <= 1'b0;
      memAddr   <= CSC_SP_RST;
      memWdata  <= CSC_WORD_RST;
      flagsWe   <= 1'b0;
      gieSet    <= 1'b0;
      gieClr    <= 1'b0;
      haltSys   <= 1'b0;
      haltCpu   <= 1'b0;
      chipReset <= 1'b0;
      wdtClear  <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      opReg     <= next_opReg;
      tgtReg    <= next_tgtReg;
      pcReg     <= next_pcReg;
      accReg    <= next_accReg;
      spReg     <= next_spReg;
      opDone    <= next_opDone;
      pcLoad    <= next_pcLoad;
      pcNext    <= next_pcNext;
      accWe     <= next_accWe;
      accData   <= next_accData;
      spWe      <= next_spWe;
      spNext    <= next_spNext;
      memWe     <= next_memWe;
      memRd     <= next_memRd;
      memAddr   <= next_memAddr;
      memWdata  <= next_memWdata;
      flagsWe   <= 1'b0;
      gieSet    <= next_gieSet;
      gieClr    <= next_gieClr;
      haltSys   <= next_haltSys;
      haltCpu   <= next_haltCpu;
      chipReset <= next_chipReset;
      wdtClear  <= next_wdtClear;
    end
  end

  // Checks on the executed sequences
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  callPush_a: assert property (
    take && opCode == CSC_OP_CALL |=> memWe && memAddr == $past(spCur)
      && memWdata[CSC_PC_W-1:0] == CSC_PC_W'($past(pcCur) + CSC_PC_STEP) && !pcLoad
      ##1 pcLoad && spWe && spNext == CSC_SP_W'($past(spCur, 2) + CSC_SP_STEP))
    else $error("call push or stack advance wrong");

  jumpTarget_a: assert property (
    take && (opCode == CSC_OP_GOTO || opCode == CSC_OP_CALL)
      |=> ##1 pcLoad && pcNext == $past(opTarget, 2))
    else $error("jump target not loaded");

  retValue_a: assert property (
    take && opCode == CSC_OP_RETIMM |=> accWe && accData == $past(opImm) && !pcLoad)
    else $error("return value not written first");

  retPop_a: assert property (
    take && opCode == CSC_OP_RET |=> spWe && memRd
      && memAddr == CSC_SP_W'($past(spCur) - CSC_SP_STEP)
      ##1 pcLoad && pcNext == $past(memRdata[CSC_PC_W-1:0]))
    else $error("return pop wrong");

  retiEnable_a: assert property (
    take && opCode == CSC_OP_RETI |=> !gieSet ##1 gieSet && pcLoad && opDone)
    else $error("interrupt enable not set after return");

  pcAdd_a: assert property (
    take && opCode == CSC_OP_PCADD
      |=> ##1 pcNext == CSC_PC_W'($past(pcCur, 2) + $past(accCur, 2)))
    else $error("computed jump wrong");

  gieOn_a: assert property (
    take && opCode == CSC_OP_INTON |=> gieSet && !gieClr)
    else $error("interrupt enable missing");

  gieOff_a: assert property (
    take && opCode == CSC_OP_INTOFF |=> gieClr && !gieSet)
    else $error("interrupt disable missing");

  haltModes_a: assert property (
    $rose(haltSys) |-> $past(take && opCode == CSC_OP_STOPSYS) && !haltCpu)
    else $error("system halt without cause");

  cpuHalt_a: assert property (
    take && opCode == CSC_OP_STOPCPU |=> haltCpu && !haltSys)
    else $error("cpu halt missing");

  swReset_a: assert property (
    take && opCode == CSC_OP_SWRST |=> chipReset && !pcLoad)
    else $error("software reset missing");

  wdtClear_a: assert property (
    take && opCode == CSC_OP_WDCLR |=> wdtClear)
    else $error("watchdog clear missing");

  twoCycle_a: assert property (
    take && csc_is_long(opCode) |=> !opDone && !opReady ##1 opDone && opReady)
    else $error("two-cycle timing wrong");

  oneCycle_a: assert property (
    take && !csc_is_long(opCode) |=> opDone && opReady)
    else $error("one-cycle timing wrong");

  flagsKept_a: assert property (
    !flagsWe)
    else $error("flags written");

  nopPc_a: assert property (
    take && opCode == CSC_OP_NOP |=> pcLoad && pcNext == CSC_PC_W'($past(pcCur) + CSC_PC_STEP)
      && !accWe && !spWe && !memWe)
    else $error("no-operation changed state");

  callSeen_c: cover property (take && opCode == CSC_OP_CALL ##2 opDone);
  retiSeen_c: cover property (take && opCode == CSC_OP_RETI ##2 gieSet);
  backToBack_c: cover property (take && !csc_is_long(opCode) ##1 take);
  pcAddSeen_c: cover property (take && opCode == CSC_OP_PCADD ##2 pcLoad);

endmodule : csc_sysctl_exec

// ---- testbench/test_csc_sysctl_exec.sv ----
module test_csc_sysctl_exec
  import csc_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [3:0]  op;
    logic [7:0]  imm;
    logic [11:0] tgt;
    logic [11:0] pc;
    logic [7:0]  acc;
    logic [7:0]  sp;
    logic [15:0] rd;
    logic [11:0] expPc;
  } csc_row_t;

  logic        coreClk;
  logic        rstn;
  logic        opValid;
  logic        opReady;
  logic [3:0]  opCode;
  logic [7:0]  opImm;
  logic [11:0] opTarget;
  logic [11:0] pcCur;
  logic [7:0]  accCur;
  logic [7:0]  spCur;
  logic [15:0] memRdata;
  logic        opDone, pcLoad, accWe, spWe, memWe, memRd, flagsWe;
  logic [11:0] pcNext;
  logic [7:0]  accData, spNext, memAddr;
  logic [15:0] memWdata;
  logic        gieSet, gieClr, haltSys, haltCpu, chipReset, wdtClear;
  logic [5:0]  strb;
  logic [5:0]  puls;
  int          errTotal;
  int          checkCount;
  int          cycleCount;
  csc_row_t    rows [15];

  // Strobe and pulse groups seen as vectors
  assign strb = {pcLoad, spWe, memWe, memRd, accWe, opDone};
  assign puls = {gieSet, gieClr, haltSys, haltCpu, chipReset, wdtClear};

  csc_sysctl_exec csc_sysctl_exec_inst (
    .core_clk(coreClk), .rstn(rstn), .opValid(opValid), .opReady(opReady),
    .opCode(opCode), .opImm(opImm), .opTarget(opTarget), .pcCur(pcCur),
    .accCur(accCur), .spCur(spCur), .memRdata(memRdata), .opDone(opDone),
    .pcLoad(pcLoad), .pcNext(pcNext), .accWe(accWe), .accData(accData),
    .spWe(spWe), .spNext(spNext), .memWe(memWe), .memRd(memRd),
    .memAddr(memAddr), .memWdata(memWdata), .flagsWe(flagsWe), .gieSet(gieSet),
    .gieClr(gieClr), .haltSys(haltSys), .haltCpu(haltCpu),
    .chipReset(chipReset), .wdtClear(wdtClear));

  // Clock at 25 MHz
  initial
  begin
    coreClk = 1'b0;
    forever #20 coreClk = ~coreClk;
  end

  // Hang guard
  always @(posedge coreClk)
  begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 2000)
    begin
      errTotal++;
      summarize();
    end
  end

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // Present one op at a falling edge and follow it to completion
  task automatic runOp(input csc_row_t r);
    logic       lng;
    logic [5:0] s1;
    logic [5:0] pul;
    lng = (r.op >= 4'h1) && (r.op <= 4'h6);
    case (r.op)
      4'h1: s1 = 6'h08;
      4'h3: s1 = 6'h16;
      4'h4, 4'h5: s1 = 6'h14;
      4'h2, 4'h6: s1 = 6'h00;
      4'hB: s1 = 6'h01;
      default: s1 = (r.op <= 4'hC) ? 6'h21 : 6'h01;
    endcase
    case (r.op)
      4'h7: pul = 6'h20;
      4'h8: pul = 6'h10;
      4'h9: pul = 6'h08;
      4'hA: pul = 6'h04;
      4'hB: pul = 6'h02;
      4'hC: pul = 6'h01;
      default: pul = 6'h00;
    endcase
    opValid = 1'b1;
    opCode = r.op;
    opImm = r.imm;
    opTarget = r.tgt;
    pcCur = r.pc;
    accCur = r.acc;
    spCur = r.sp;
    memRdata = r.rd;
    @(negedge coreClk);
    opValid = 1'b0;
    chk(16'(strb), 16'(s1));
    chk(16'(puls), 16'(pul));
    chk(16'(flagsWe), 16'h0000);
    chk(16'(opReady), 16'(!lng));
    if (r.op == 4'h1)
    begin
      chk(16'(memAddr), 16'(r.sp));
      chk(memWdata, {4'h0, 12'(r.pc + 12'h001)});
    end
    if (r.op == 4'h3 || r.op == 4'h4 || r.op == 4'h5)
    begin
      chk(16'(spNext), 16'(8'(r.sp - 8'h02)));
      chk(16'(memAddr), 16'(8'(r.sp - 8'h02)));
    end
    if (r.op == 4'h3)
      chk(16'(accData), 16'(r.imm));
    if (!lng && s1[5])
      chk(16'(pcNext), 16'(r.expPc));
    if (lng)
    begin
      @(negedge coreClk);
      chk(16'(strb), {10'h000, 1'b1, r.op == 4'h1, 4'h1});
      chk(16'(puls), (r.op == 4'h5) ? 16'h0020 : 16'h0000);
      chk(16'(pcNext), 16'(r.expPc));
      chk(16'(opReady), 16'h0001);
      if (r.op == 4'h1)
        chk(16'(spNext), 16'(8'(r.sp + 8'h02)));
    end
    memRdata = ~r.rd;
    @(negedge coreClk);
    $display("test op %h done", r.op);
  endtask : runOp

  initial
  begin
    // Op, imm, target, pc, acc, sp, stack word, expected pc
    rows = '{
      '{4'h0, 8'h00, 12'h000, 12'h234, 8'h00, 8'h00, 16'h0000, 12'h235},
      '{4'h1, 8'h00, 12'hABC, 12'hFFF, 8'h00, 8'hFE, 16'h0000, 12'hABC},
      '{4'h2, 8'h00, 12'hFFF, 12'h010, 8'h00, 8'h00, 16'h0000, 12'hFFF},
      '{4'h3, 8'hA5, 12'h000, 12'h020, 8'h00, 8'h10, 16'hF456, 12'h456},
      '{4'h4, 8'h00, 12'h000, 12'h030, 8'h00, 8'h00, 16'h0789, 12'h789},
      '{4'h5, 8'h00, 12'h000, 12'h040, 8'h00, 8'h40, 16'h0ACE, 12'hACE},
      '{4'h6, 8'h00, 12'h000, 12'hFFE, 8'h05, 8'h00, 16'h0000, 12'h003},
      '{4'h6, 8'h00, 12'h000, 12'h100, 8'hFF, 8'h00, 16'h0000, 12'h1FF},
      '{4'h7, 8'h00, 12'h000, 12'h010, 8'h00, 8'h00, 16'h0000, 12'h011},
      '{4'h8, 8'h00, 12'h000, 12'h020, 8'h00, 8'h00, 16'h0000, 12'h021},
      '{4'h9, 8'h00, 12'h000, 12'h030, 8'h00, 8'h00, 16'h0000, 12'h031},
      '{4'hA, 8'h00, 12'h000, 12'hFFF, 8'h00, 8'h00, 16'h0000, 12'h000},
      '{4'hB, 8'h00, 12'h000, 12'h050, 8'h00, 8'h00, 16'h0000, 12'h000},
      '{4'hC, 8'h00, 12'h000, 12'h060, 8'h00, 8'h00, 16'h0000, 12'h061},
      '{4'hF, 8'h00, 12'h000, 12'h070, 8'h00, 8'h00, 16'h0000, 12'h000}};
    errTotal = 0;
    checkCount = 0;
    cycleCount = 0;
    rstn = 1'b0;
    {opValid, opCode, opImm, opTarget, pcCur, accCur, spCur} = '0;
    memRdata = 16'hFFFF;
    repeat (2) @(negedge coreClk);
    chk({strb, puls, opReady}, 16'h0001);
    chk(16'(pcNext), 16'h0000);
    rstn = 1'b1;
    $display("test reset done");
    foreach (rows[i])
      runOp(rows[i]);
    // Back-to-back single-cycle ops
    opValid = 1'b1;
    opCode = 4'h7;
    pcCur = 12'h100;
    @(negedge coreClk);
    opCode = 4'h8;
    pcCur = 12'h200;
    chk(16'(puls), 16'h0020);
    chk(16'(pcNext), 16'h0101);
    @(negedge coreClk);
    opValid = 1'b0;
    chk(16'(puls), 16'h0010);
    chk(16'(pcNext), 16'h0201);
    @(negedge coreClk);
    $display("test back to back done");
    // Op offered during the second cycle of a call is ignored
    opValid = 1'b1;
    opCode = 4'h1;
    opTarget = 12'h321;
    pcCur = 12'h010;
    spCur = 8'h20;
    @(negedge coreClk);
    opCode = 4'h2;
    opTarget = 12'h777;
    chk(16'(opReady), 16'h0000);
    @(negedge coreClk);
    opValid = 1'b0;
    chk(16'(pcNext), 16'h0321);
    chk(16'(spNext), 16'h0022);
    @(negedge coreClk);
    chk(16'(strb), 16'h0000);
    $display("test refusal done");
    // Reset in the middle of a call
    opValid = 1'b1;
    opCode = 4'h1;
    @(negedge coreClk);
    opValid = 1'b0;
    rstn = 1'b0;
    @(negedge coreClk);
    rstn = 1'b1;
    chk({strb, puls, opReady}, 16'h0001);
    chk({spNext, memAddr}, 16'h0000);
    @(negedge coreClk);
    chk(16'(strb), 16'h0000);
    $display("test mid reset done");
    summarize();
  end

endmodule : test_csc_sysctl_exec
